//--- bench/host_desc_model.sv
// Host side model: link clocks and descriptor read-back after release
`timescale 1ns/1ps
module host_desc_model
    import tx_status_pkg::*;
(
    input wire logic core_clk,
    input wire logic own_release,
    input wire logic [WORD_W-1:0] status_word,
    output logic crystal_clock_in,
    output logic serial_transmit_clock,
    output logic [WORD_W-1:0] host_word,
    output logic [DIST_W-1:0] host_dist
);
    // ****************************************
    // Link clocks
    // ****************************************
    // Both run free; phase offset keeps them unrelated to the core clock
    initial
    begin
        crystal_clock_in = 1'b0;
        #7.5;
        forever #25 crystal_clock_in = ~crystal_clock_in;
    end

    initial
    begin
        serial_transmit_clock = 1'b0;
        #3;
        forever #16 serial_transmit_clock = ~serial_transmit_clock;
    end

    // ****************************************
    // Descriptor read-back
    // ****************************************
    // Word read only once ownership is back; a fresh copy stands for a cleared word
    initial host_word = '0;
    always @(posedge core_clk)
    begin
        if (own_release === 1'b1)
            host_word <= status_word;
    end

    // Distance trusted only with retry exhausted; loopback is never used
    assign host_dist = host_word[RETRY_EX_BIT] ? host_word[DIST_LSB +: DIST_W] : '0;
    // Last-buffer flag and length come from the bench, never from the device
endmodule

//--- bench/tb.sv
// Self-checking bench for the transmit status write-back sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb
    import tx_status_pkg::*;
;
    localparam logic [6:0] EN = 7'h40;
    localparam logic [6:0] ATT = 7'h20;
    localparam logic [6:0] COL = 7'h10;
    localparam logic [6:0] BEND = 7'h08;
    localparam logic [6:0] EMPTY = 7'h04;
    localparam logic [6:0] DONE = 7'h02;
    localparam logic [6:0] CLOST = 7'h01;
    // Distance field left out where its value is not the point
    localparam logic [31:0] MSK = 32'hfc00_ffff;

    logic core_clk, nrst, attempt_start, tx_collision, slot_time_past, carrier_sense_in;
    logic builtin_attachment_unit, builtin_carrier_lost, buffer_end, last_buffer_flag;
    logic next_owned, next_status_fetched, fifo_empty_early, packet_done;
    logic transmitter_enable, single_attempt_setting, serial_port_choice;
    logic crystal_clock_in, serial_transmit_clock;
    logic transmitter_on, truncate_frame, retry_request, status_valid, status_last, own_release;
    logic [WORD_W-1:0] status_word, host_word;
    logic [DIST_W-1:0] host_dist;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_trunc = 0;
    int n_retry = 0;

    tx_descriptor_status_writeback u_dut (.core_clk(core_clk), .nrst(nrst),
        .attempt_start(attempt_start), .tx_collision(tx_collision),
        .slot_time_past(slot_time_past), .carrier_sense_in(carrier_sense_in),
        .builtin_attachment_unit(builtin_attachment_unit),
        .builtin_carrier_lost(builtin_carrier_lost), .buffer_end(buffer_end),
        .last_buffer_flag(last_buffer_flag), .next_owned(next_owned),
        .next_status_fetched(next_status_fetched), .fifo_empty_early(fifo_empty_early),
        .packet_done(packet_done), .transmitter_enable(transmitter_enable),
        .single_attempt_setting(single_attempt_setting),
        .serial_port_choice(serial_port_choice), .crystal_clock_in(crystal_clock_in),
        .serial_transmit_clock(serial_transmit_clock), .transmitter_on(transmitter_on),
        .truncate_frame(truncate_frame), .retry_request(retry_request),
        .status_valid(status_valid), .status_word(status_word),
        .status_last(status_last), .own_release(own_release));

    host_desc_model u_host (.core_clk(core_clk), .own_release(own_release),
        .status_word(status_word), .crystal_clock_in(crystal_clock_in),
        .serial_transmit_clock(serial_transmit_clock), .host_word(host_word),
        .host_dist(host_dist));

    // ****************************************
    // Clock, pulse counters, helpers
    // ****************************************
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        if (truncate_frame === 1'b1)
            n_trunc++;
        if (retry_request === 1'b1)
            n_retry++;
    end

    // Flags 31,30,28,27,26 then retry count
    function automatic logic [31:0] w(input logic [4:0] f, input logic [3:0] r);
        w = {f[4:3], 1'b0, f[2:0], 22'h0, r};
    endfunction

    task automatic ev(input logic [6:0] m);
        @(posedge core_clk);
        {transmitter_enable, attempt_start, tx_collision, buffer_end, fifo_empty_early,
            packet_done, builtin_carrier_lost} <= m;
        @(posedge core_clk);
        {transmitter_enable, attempt_start, tx_collision, buffer_end, fifo_empty_early,
            packet_done, builtin_carrier_lost} <= 7'h00;
    endtask

    task automatic start();
        int i;
        n_trunc = 0;
        n_retry = 0;
        ev(EN);
        for (i = 0; i < 20 && transmitter_on !== 1'b1; i++)
            @(posedge core_clk);
        ev(ATT);
        repeat (2) @(posedge core_clk);
    endtask

    task automatic wait_word(input logic [31:0] exp, input int tr, input int rt);
        int i;
        for (i = 0; i < 60 && status_valid !== 1'b1; i++)
            @(posedge core_clk);
        `CHK(status_valid, 1'b1)
        `CHK(status_word & MSK, exp)
        `CHK(status_last, last_buffer_flag)
        @(posedge core_clk);
        `CHK(own_release, 1'b1)
        repeat (2) @(posedge core_clk);
        `CHK(host_word & MSK, exp)
        `CHK(n_trunc, tr)
        `CHK(n_retry, rt)
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_retry_ok();
        last_buffer_flag <= 1'b1;
        start();
        ev(COL);
        repeat (2) @(posedge core_clk);
        ev(ATT);
        ev(DONE);
        wait_word(w(5'b00000, 4'h1), 0, 1);
    endtask

    task automatic t_buf_unowned();
        last_buffer_flag <= 1'b0;
        next_owned <= 1'b0;
        start();
        // One retry first, so a non-last word must still show no retry count
        ev(COL);
        repeat (2) @(posedge core_clk);
        ev(ATT);
        ev(BEND);
        wait_word(w(5'b11000, 4'h0), 1, 1);
        `CHK(transmitter_on, 1'b0)
        next_owned <= 1'b1;
    endtask

    task automatic t_buf_unfetched();
        last_buffer_flag <= 1'b0;
        next_status_fetched <= 1'b0;
        start();
        ev(EMPTY);
        wait_word(w(5'b11000, 4'h0), 1, 0);
        `CHK(transmitter_on, 1'b0)
        next_status_fetched <= 1'b1;
    endtask

    task automatic t_underflow();
        last_buffer_flag <= 1'b1;
        start();
        ev(EMPTY);
        wait_word(w(5'b01000, 4'h0), 1, 0);
        `CHK(transmitter_on, 1'b0)
    endtask

    task automatic t_late();
        slot_time_past <= 1'b1;
        start();
        ev(COL);
        wait_word(w(5'b00100, 4'h0), 0, 0);
        slot_time_past <= 1'b0;
    endtask

    task automatic t_carrier_pin();
        start();
        carrier_sense_in <= 1'b0;
        repeat (6) @(posedge core_clk);
        ev(COL);
        ev(DONE);
        wait_word(w(5'b00010, 4'h0), 0, 0);
        carrier_sense_in <= 1'b1;
    endtask

    task automatic t_carrier_int();
        builtin_attachment_unit <= 1'b1;
        start();
        ev(CLOST);
        ev(DONE);
        wait_word(w(5'b00010, 4'h0), 0, 0);
        builtin_attachment_unit <= 1'b0;
    endtask

    task automatic t_exhaust();
        int i;
        start();
        for (i = 0; i < 15; i++)
        begin
            ev(COL);
            repeat (2) @(posedge core_clk);
            ev(ATT);
        end
        ev(COL);
        wait_word(w(5'b00001, ATT_SAT), 0, 15);
    endtask

    task automatic t_single(input logic sel, input int lo, input int hi);
        single_attempt_setting <= 1'b1;
        serial_port_choice <= sel;
        start();
        repeat (100) @(posedge core_clk);
        ev(COL);
        wait_word(w(5'b00001, 4'h1), 0, 0);
        `CHK(host_dist >= lo && host_dist <= hi, 1'b1)
        single_attempt_setting <= 1'b0;
    endtask

    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        results();
    end

    initial
    begin
        nrst = 1'b0;
        {transmitter_enable, attempt_start, tx_collision, buffer_end, fifo_empty_early,
            packet_done, builtin_carrier_lost} = 7'h00;
        slot_time_past = 1'b0;
        carrier_sense_in = 1'b1;
        builtin_attachment_unit = 1'b0;
        last_buffer_flag = 1'b1;
        next_owned = 1'b1;
        next_status_fetched = 1'b1;
        single_attempt_setting = 1'b0;
        serial_port_choice = 1'b0;
        repeat (6) @(posedge core_clk);
        `CHK({transmitter_on, truncate_frame, retry_request, status_valid}, 4'h0)
        `CHK({status_last, own_release, status_word}, 34'h0)
        nrst <= 1'b1;
        t_retry_ok();
        t_buf_unowned();
        t_buf_unfetched();
        t_underflow();
        t_late();
        t_carrier_pin();
        t_carrier_int();
        t_exhaust();
        // Crystal gives about 8 rises in 416 ns, transmit clock about 13
        t_single(1'b0, 7, 10);
        t_single(1'b1, 11, 15);
        results();
    end
endmodule

//--- verilog/fault_count_if.sv
// Link between the status sequencer and the fault distance counter
`timescale 1ns/1ps
interface fault_count_if;
    logic clear;
    logic run;
    logic port_choice;
    logic xtal_rise;
    logic txc_rise;
    logic [9:0] count;
    modport ctrl (output clear, output run, output port_choice, output xtal_rise,
        output txc_rise, input count);
    modport counter (input clear, input run, input port_choice, input xtal_rise,
        input txc_rise, output count);
endinterface

//--- verilog/fault_distance_counter.sv
// Fault distance counter advanced by sampled crystal or transmit clock edges
`timescale 1ns/1ps
module fault_distance_counter
    import tx_status_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    fault_count_if.counter fc
);
    logic [DIST_W-1:0] count;
    logic [DIST_W-1:0] next_count;
    logic tick;

    always_comb
    begin
        tick = fc.port_choice ? fc.txc_rise : fc.xtal_rise;
        next_count = count;
        if (fc.clear)
            next_count = '0;
        else if (fc.run && tick)
            next_count = count + DIST_ONE;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            count <= '0;
        else
            count <= next_count;
    end

    assign fc.count = count;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    count_step_a: assert property (fc.run && !fc.clear && tick |=> count == $past(count) + DIST_ONE)
        else $error("distance count did not step on the chosen clock");
    count_hold_a: assert property (!fc.run && !fc.clear |=> $stable(count))
        else $error("distance count moved while stopped");
endmodule

//--- verilog/pin_edge_sampler.sv
// Two-flop synchroniser with rise and fall detection for an outside pin
`timescale 1ns/1ps
module pin_edge_sampler (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level = sync;
    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule

//--- verilog/tx_descriptor_status_writeback.sv
// Transmit status sequencer: builds and writes back descriptor word two
`timescale 1ns/1ps
module tx_descriptor_status_writeback
    import tx_status_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic attempt_start,
    input wire logic tx_collision,
    input wire logic slot_time_past,
    input wire logic carrier_sense_in,
    input wire logic builtin_attachment_unit,
    input wire logic builtin_carrier_lost,
    input wire logic buffer_end,
    input wire logic last_buffer_flag,
    input wire logic next_owned,
    input wire logic next_status_fetched,
    input wire logic fifo_empty_early,
    input wire logic packet_done,
    input wire logic transmitter_enable,
    input wire logic single_attempt_setting,
    input wire logic serial_port_choice,
    input wire logic crystal_clock_in,
    input wire logic serial_transmit_clock,
    output logic transmitter_on,
    output logic truncate_frame,
    output logic retry_request,
    output logic status_valid,
    output logic [WORD_W-1:0] status_word,
    output logic status_last,
    output logic own_release
);
    // ****************************************************************
    // Pin sampling and distance counter
    // ****************************************************************
    fault_count_if fc ();
    logic cs_level;
    logic cs_fall;
    logic xtal_rise;
    logic txc_rise;

    pin_edge_sampler cs_sampler (
        .core_clk(core_clk),
        .nrst(nrst),
        .pin(carrier_sense_in),
        .level(cs_level),
        .rise(),
        .fall(cs_fall)
    );

    pin_edge_sampler xtal_sampler (
        .core_clk(core_clk),
        .nrst(nrst),
        .pin(crystal_clock_in),
        .level(),
        .rise(xtal_rise),
        .fall()
    );

    pin_edge_sampler txc_sampler (
        .core_clk(core_clk),
        .nrst(nrst),
        .pin(serial_transmit_clock),
        .level(),
        .rise(txc_rise),
        .fall()
    );

    fault_distance_counter distance (
        .core_clk(core_clk),
        .nrst(nrst),
        .fc(fc.counter)
    );

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    state_e state;
    state_e next_state;
    logic buf_err;
    logic starved;
    logic late_col;
    logic car_lost;
    logic retry_ex;
    logic [4:0] fails;
    logic cnt_run;
    logic cnt_clear;
    logic next_buf_err;
    logic next_starved;
    logic next_late_col;
    logic next_car_lost;
    logic next_retry_ex;
    logic [4:0] next_fails;
    logic next_cnt_run;
    logic next_cnt_clear;
    logic next_transmitter_on;
    logic next_truncate;
    logic next_retry_request;
    logic next_status_valid;
    logic [WORD_W-1:0] next_status_word;
    logic next_status_last;
    logic next_own_release;
    logic sending;
    logic carrier_drop;
    logic chain_stall;
    logic starve_event;
    logic early_collision;

    assign fc.clear = cnt_clear;
    assign fc.run = cnt_run;
    assign fc.port_choice = serial_port_choice;
    assign fc.xtal_rise = xtal_rise;
    assign fc.txc_rise = txc_rise;

    always_comb
    begin
        sending = (state == ST_SEND);
        // Internal unit reports loss itself; serial port watches carrier sense
        carrier_drop = builtin_attachment_unit ? builtin_carrier_lost : cs_fall;
        chain_stall = buffer_end && !last_buffer_flag && !next_owned;
        starve_event = fifo_empty_early;
        early_collision = tx_collision && !slot_time_past;

        next_state = state;
        next_buf_err = buf_err;
        next_starved = starved;
        next_late_col = late_col;
        next_car_lost = car_lost;
        next_retry_ex = retry_ex;
        next_fails = fails;
        next_cnt_run = cnt_run;
        next_cnt_clear = 1'b0;
        next_transmitter_on = transmitter_on | transmitter_enable;
        next_truncate = 1'b0;
        next_retry_request = 1'b0;
        next_status_valid = 1'b0;
        next_status_word = status_word;
        next_status_last = status_last;
        next_own_release = 1'b0;

        case (state)
            ST_IDLE:
            begin
                if (attempt_start && transmitter_on)
                begin
                    next_buf_err = 1'b0;
                    next_starved = 1'b0;
                    next_late_col = 1'b0;
                    next_car_lost = 1'b0;
                    next_retry_ex = 1'b0;
                    next_fails = '0;
                    next_cnt_clear = 1'b1;
                    next_cnt_run = 1'b1;
                    next_state = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (attempt_start)
                begin
                    next_cnt_clear = 1'b1;
                    next_cnt_run = 1'b1;
                end
                if (carrier_drop && !car_lost)
                begin
                    next_car_lost = 1'b1;
                    next_cnt_run = 1'b0;
                end
                if (chain_stall || (starve_event && !last_buffer_flag && !next_status_fetched))
                begin
                    next_buf_err = 1'b1;
                    next_starved = 1'b1;
                    next_transmitter_on = 1'b0;
                    next_truncate = 1'b1;
                    next_state = ST_WRITE;
                end
                else if (starve_event)
                begin
                    next_starved = 1'b1;
                    next_transmitter_on = 1'b0;
                    next_truncate = 1'b1;
                    next_state = ST_WRITE;
                end
                else if (tx_collision && slot_time_past)
                begin
                    next_late_col = 1'b1;
                    next_cnt_run = 1'b0;
                    next_state = ST_WRITE;
                end
                else if (early_collision && !car_lost)
                begin
                    next_fails = fails + 5'h01;
                    next_cnt_run = 1'b0;
                    if (single_attempt_setting || next_fails == MAX_ATTEMPTS)
                    begin
                        next_retry_ex = 1'b1;
                        next_state = ST_WRITE;
                    end
                    else
                        next_retry_request = 1'b1;
                end
                else if (packet_done)
                begin
                    // Carrier loss lets the packet run to its end, no retry unless a collision comes in the drop's own cycle
                    next_state = ST_WRITE;
                end
            end
            ST_WRITE:
            begin
                next_status_word = '0;
                next_status_word[BUF_ERR_BIT] = buf_err;
                next_status_word[STARVED_BIT] = starved;
                next_status_word[LATE_COL_BIT] = late_col;
                next_status_word[CAR_LOST_BIT] = car_lost;
                next_status_word[RETRY_EX_BIT] = retry_ex;
                next_status_word[DIST_LSB +: DIST_W] = fc.count;
                if (last_buffer_flag)
                    next_status_word[ATT_W-1:0] = sat_retries(fails);
                next_status_last = last_buffer_flag;
                next_status_valid = 1'b1;
                next_state = ST_RELEASE;
            end
            ST_RELEASE:
            begin
                // Ownership only goes back once the word has been written
                next_own_release = 1'b1;
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            state <= ST_IDLE;
            buf_err <= 1'b0;
            starved <= 1'b0;
            late_col <= 1'b0;
            car_lost <= 1'b0;
            retry_ex <= 1'b0;
            fails <= '0;
            cnt_run <= 1'b0;
            cnt_clear <= 1'b0;
            transmitter_on <= 1'b0;
            truncate_frame <= 1'b0;
            retry_request <= 1'b0;
            status_valid <= 1'b0;
            status_word <= '0;
            status_last <= 1'b0;
            own_release <= 1'b0;
        end
        else
        begin
            state <= next_state;
            buf_err <= next_buf_err;
            starved <= next_starved;
            late_col <= next_late_col;
            car_lost <= next_car_lost;
            retry_ex <= next_retry_ex;
            fails <= next_fails;
            cnt_run <= next_cnt_run;
            cnt_clear <= next_cnt_clear;
            transmitter_on <= next_transmitter_on;
            truncate_frame <= next_truncate;
            retry_request <= next_retry_request;
            status_valid <= next_status_valid;
            status_word <= next_status_word;
            status_last <= next_status_last;
            own_release <= next_own_release;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    buf_starved_a: assert property (status_valid |-> !status_word[BUF_ERR_BIT] || status_word[STARVED_BIT])
        else $error("buffer error written without underflow");
    rsvd_zero_a: assert property (status_valid |-> !status_word[RSVD_BIT])
        else $error("reserved bit written as one");
    stall_off_a: assert property (sending && chain_stall |=> !transmitter_on ##1 status_valid && status_word[BUF_ERR_BIT])
        else $error("buffer error did not stop transmitter");
    starve_trunc_a: assert property (sending && starve_event |=> truncate_frame && !transmitter_on ##1 status_valid && status_word[STARVED_BIT])
        else $error("underflow not truncated and flagged");
    late_no_retry_a: assert property (sending && !chain_stall && !starve_event && tx_collision && slot_time_past |=> !retry_request ##1 status_word[LATE_COL_BIT])
        else $error("late collision retried or unflagged");
    single_try_a: assert property (sending && !chain_stall && !starve_event && early_collision && !car_lost && single_attempt_setting |=> !retry_request ##1 status_valid && status_word[RETRY_EX_BIT])
        else $error("single attempt setting ignored");
    sixteen_fail_a: assert property (sending && !chain_stall && !starve_event && early_collision && !car_lost && fails == 5'h0f |=> ##1 status_word[RETRY_EX_BIT])
        else $error("retry exhaustion missed after sixteen");
    lost_no_retry_a: assert property (car_lost |-> !next_retry_request)
        else $error("retry requested after carrier loss");
    last_only_a: assert property (status_valid && !status_last |-> status_word[ATT_W-1:0] == '0)
        else $error("retry count in non-last descriptor");
    retry_sat_a: assert property (status_valid && status_word[RETRY_EX_BIT] && status_last && !single_attempt_setting |-> status_word[ATT_W-1:0] == ATT_SAT)
        else $error("retry count not saturated");
    write_release_a: assert property (status_valid |=> own_release && $stable(status_word))
        else $error("ownership not returned after write");
    cs_lost_a: assert property (sending && !builtin_attachment_unit && cs_fall && !car_lost |=> car_lost)
        else $error("carrier sense drop not flagged");

    retry_seen_c: cover property (retry_request ##[1:50] status_valid && status_word[RETRY_EX_BIT]);
    buf_err_seen_c: cover property (status_valid && status_word[BUF_ERR_BIT]);
    clean_send_c: cover property (status_valid && status_last && status_word[WORD_W-1:DIST_LSB] == '0);
    lost_done_c: cover property (status_valid && status_word[CAR_LOST_BIT] && cs_level == 1'b0);
endmodule

//--- verilog/tx_status_pkg.sv
// Constants, layout and states of the transmit status word write-back
// Notes on behaviour
// - Flag buffer error when current buffer is not last and next is unobtainable.
// - Buffer error: next descriptor not owned, or underflow before next status fetched.
// - A buffer error turns the transmitter off.
// - Every buffer error also raises the underflow flag.
// - FIFO empty before packet end: truncate, flag underflow, transmitter off.
// - Reserved bit 29 is always written as zero.
// - Collision after slot time: flag late collision and do not retry.
// - Carrier drop during own send sets carrier-lost; internal or carrier-sense input.
// - After carrier loss no retry; the whole packet is still sent. A collision in the same cycle as the drop still retries.
// - Sixteen failed collision attempts set the retry-exhausted flag.
// - With single-attempt setting, one failed attempt sets retry-exhausted.
// - Bits 25-16 report count from send start to collision or carrier loss.
// - Distance counts crystal clock when port choice is 0, transmit clock when 1.
// - Bits 3-0 hold the retry count, saturating at 15.
// - Retry count goes only into the last descriptor; host reads after release.
package tx_status_pkg;
    localparam int WORD_W = 32;
    localparam int BUF_ERR_BIT = 31;
    localparam int STARVED_BIT = 30;
    localparam int RSVD_BIT = 29;
    localparam int LATE_COL_BIT = 28;
    localparam int CAR_LOST_BIT = 27;
    localparam int RETRY_EX_BIT = 26;
    localparam int DIST_LSB = 16;
    localparam int DIST_W = 10;
    localparam int ATT_W = 4;
    localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
    localparam logic [ATT_W-1:0] ATT_SAT = 4'hf;
    localparam logic [DIST_W-1:0] DIST_ONE = 10'h001;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SEND = 4'h2,
        ST_WRITE = 4'h4,
        ST_RELEASE = 4'h8
    } state_e;

    // Failed attempts to retries: 16 failures mean 15 retries were made
    function automatic logic [ATT_W-1:0] sat_retries(input logic [4:0] fails);
        sat_retries = (fails > {1'b0, ATT_SAT}) ? ATT_SAT : fails[ATT_W-1:0];
    endfunction
endpackage
